// ===== logic/sgf_pkg.sv
package sgf_pkg;
   // register addresses
   localparam logic [7:0] ADDR_MCAST_CTRL = 8'h86;
   localparam logic [7:0] ADDR_RATE_TAG = 8'h87;
   localparam logic [7:0] ADDR_REV_IDENT = 8'h89;
   localparam logic [7:0] ADDR_CLASS_MAP = 8'h90;
   // fields of the multicast control register
   localparam int MC_MAP_LSB = 0;
   localparam int MC_MAP_W = 5;
   localparam int MC_SELF_FILT_BIT = 6;
   localparam int MC_FWD_EN_BIT = 5;
   // fields of the rate and tag control register
   localparam int RT_PERIOD_LSB = 4;
   localparam int RT_QUEUE_BIT = 3;
   localparam int RT_SRC_TAG_BIT = 2;
   // fields of the revision register and class map
   localparam int REV_LSB = 4;
   localparam int CM_CLASS3_LSB = 6;
   localparam int CM_CLASS2_LSB = 4;
   localparam int CM_LOW_LSB = 0;
   // reset values
   localparam logic [4:0] RST_MC_MAP = 5'h00;
   localparam logic [1:0] RST_PERIOD = 2'h1;
   localparam logic [1:0] RST_PRIO = 2'h0;
   localparam logic [3:0] RST_LOW_MAP = 4'h0;
   // revision value, arbitrary
   localparam logic [3:0] REV_DEFAULT = 4'hA;
   // traffic class codes matched by the map
   localparam logic [5:0] CLASS_TWO = 6'h02;
   localparam logic [5:0] CLASS_THREE = 6'h03;
   // period codes and times
   localparam logic [1:0] PER_CODE_16 = 2'h0;
   localparam logic [1:0] PER_CODE_64 = 2'h1;
   localparam int CLK_MHZ = 250;
   localparam longint PER_16_MS = 16;
   localparam longint PER_64_MS = 64;
   localparam longint PER_256_MS = 256;
   localparam longint PER_16_CYC = PER_16_MS * 1000 * CLK_MHZ;
   localparam longint PER_64_CYC = PER_64_MS * 1000 * CLK_MHZ;
   localparam longint PER_256_CYC = PER_256_MS * 1000 * CLK_MHZ;
   typedef enum logic [1:0] {SGF_PER_16, SGF_PER_64, SGF_PER_256} sgf_period_e;
endpackage

// ===== logic/sgf_period_timer.sv
`timescale 1ns/1ns
// free-running period timer: pulses tick at the end of each measuring window
module sgf_period_timer #(
   parameter int CNT_W = 27,
   parameter logic [CNT_W-1:0] CYC_16 = CNT_W'(sgf_pkg::PER_16_CYC),
   parameter logic [CNT_W-1:0] CYC_64 = CNT_W'(sgf_pkg::PER_64_CYC),
   parameter logic [CNT_W-1:0] CYC_256 = CNT_W'(sgf_pkg::PER_256_CYC)
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [1:0] period_code,
   output logic tick
);
   logic [CNT_W-1:0] count;
   wire logic [CNT_W-1:0] limit;
   wire logic at_end;

   // code decode, upper bit set selects the long window
   assign limit = period_code[1] ? CYC_256 :
                  (period_code == sgf_pkg::PER_CODE_64) ? CYC_64 : CYC_16;
   assign at_end = (count >= limit - CNT_W'(1));

   // count and wrap; a shortened code ends the window at once
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         count <= '0;
         tick <= 1'b0;
      end else begin
         count <= at_end ? '0 : count + CNT_W'(1);
         tick <= at_end;
      end
   end
endmodule

// ===== logic/sgf_global_cfg.sv
`timescale 1ns/1ns
// Summary of operation
// - five-bit unknown IP multicast port map, zero drops, all ones floods, resets zero
// - each map bit selects one port, bit 0 is port 1
// - the map is used only while the forwarding enable bit is set
// - two-bit ingress period: 00 16 ms, 01 64 ms, 1x 256 ms, resets 01
// - bit 3 picks per-queue egress limiting when set, per-port when clear
// - bit 2 set: tag insertion decided per source port at each egress
// - bit 2 clear: tag insertion follows a single per-port control bit
// - read-only four-bit revision in the upper nibble of the ident register
// - traffic class 0x03 takes priority from map bits 7 to 6, reset 00
// - traffic class 0x02 takes priority from map bits 5 to 4, reset 00
module sgf_global_cfg #(
   parameter int PORTS = 5,
   parameter int CNT_W = 27,
   parameter logic [CNT_W-1:0] CYC_16 = CNT_W'(sgf_pkg::PER_16_CYC),
   parameter logic [CNT_W-1:0] CYC_64 = CNT_W'(sgf_pkg::PER_64_CYC),
   parameter logic [CNT_W-1:0] CYC_256 = CNT_W'(sgf_pkg::PER_256_CYC),
   parameter logic [3:0] REV_ID = sgf_pkg::REV_DEFAULT
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic mcast_lookup,
   input wire logic [5:0] frame_class,
   input wire logic frame_is_ip,
   input wire logic [PORTS-1:0] src_port_tag_ctrl,
   input wire logic [PORTS-1:0] port_tag_ctrl,
   output logic [PORTS-1:0] mcast_dest,
   output logic mcast_forward,
   output logic [1:0] frame_prio,
   output logic frame_prio_valid,
   output logic [PORTS-1:0] tag_insert,
   output logic queue_egress_limit,
   output logic [1:0] ingress_period,
   output logic ingress_tick
);
   ////////////////////////////////////////////////////////////////////////////
   // register storage
   logic [4:0] mc_map;
   logic mc_fwd_en;
   logic self_filter;
   logic [1:0] period;
   logic queue_mode;
   logic src_tag_sel;
   logic [1:0] prio_for_class_three;
   logic [1:0] prio_for_class_two;
   logic [3:0] prio_low_map;
   logic timer_tick;

   // address decode
   wire logic hit_mc = (reg_addr == sgf_pkg::ADDR_MCAST_CTRL);
   wire logic hit_rt = (reg_addr == sgf_pkg::ADDR_RATE_TAG);
   wire logic hit_id = (reg_addr == sgf_pkg::ADDR_REV_IDENT);
   wire logic hit_cm = (reg_addr == sgf_pkg::ADDR_CLASS_MAP);
   wire logic wr_mc = reg_wr && hit_mc;
   wire logic wr_rt = reg_wr && hit_rt;
   wire logic wr_cm = reg_wr && hit_cm;

   // read views; reserved bits are constant zero
   wire logic [7:0] view_mc = {1'b0, self_filter, mc_fwd_en, mc_map};
   wire logic [7:0] view_rt = {2'b00, period, queue_mode, src_tag_sel, 2'b00};
   wire logic [7:0] view_id = {REV_ID, 4'h0};
   wire logic [7:0] view_cm = {prio_for_class_three, prio_for_class_two, prio_low_map};
   wire logic [7:0] next_rdata = hit_mc ? view_mc :
                                 hit_rt ? view_rt :
                                 hit_id ? view_id :
                                 hit_cm ? view_cm : 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // multicast control register writes
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         mc_map <= sgf_pkg::RST_MC_MAP;
         mc_fwd_en <= 1'b0;
         self_filter <= 1'b0;
      end else if (wr_mc) begin
         mc_map <= reg_wdata[sgf_pkg::MC_MAP_LSB +: sgf_pkg::MC_MAP_W];
         mc_fwd_en <= reg_wdata[sgf_pkg::MC_FWD_EN_BIT];
         self_filter <= reg_wdata[sgf_pkg::MC_SELF_FILT_BIT];
      end
   end

   // rate and tag control writes, reserved bits dropped
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         period <= sgf_pkg::RST_PERIOD;
         queue_mode <= 1'b0;
         src_tag_sel <= 1'b0;
      end else if (wr_rt) begin
         period <= reg_wdata[sgf_pkg::RT_PERIOD_LSB +: 2];
         queue_mode <= reg_wdata[sgf_pkg::RT_QUEUE_BIT];
         src_tag_sel <= reg_wdata[sgf_pkg::RT_SRC_TAG_BIT];
      end
   end

   // traffic class map writes
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         prio_for_class_three <= sgf_pkg::RST_PRIO;
         prio_for_class_two <= sgf_pkg::RST_PRIO;
         prio_low_map <= sgf_pkg::RST_LOW_MAP;
      end else if (wr_cm) begin
         prio_for_class_three <= reg_wdata[sgf_pkg::CM_CLASS3_LSB +: 2];
         prio_for_class_two <= reg_wdata[sgf_pkg::CM_CLASS2_LSB +: 2];
         prio_low_map <= reg_wdata[sgf_pkg::CM_LOW_LSB +: 4];
      end
   end

   // read data, valid only in the cycle after the strobe
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= reg_rd ? next_rdata : 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // unknown IP multicast destination and tag source, one slice per egress port
   wire logic [PORTS-1:0] map_wide;
   wire logic [PORTS-1:0] next_dest;
   wire logic [PORTS-1:0] next_tag;

   // ports beyond the map width are never chosen, so a wider switch stays safe
   for (genvar p = 0; p < PORTS; p++) begin : g_port
      if (p < sgf_pkg::MC_MAP_W) begin : g_mapped
         assign map_wide[p] = mc_map[p];
      end else begin : g_unmapped
         assign map_wide[p] = 1'b0;
      end
      // a clear enable masks every port at once
      assign next_dest[p] = mc_fwd_en && map_wide[p];
      // per source control when bit 2 is set, single control otherwise
      assign next_tag[p] = src_tag_sel ? src_port_tag_ctrl[p] : port_tag_ctrl[p];
   end

   wire logic next_forward = mcast_lookup && mc_fwd_en && (mc_map != 5'h00);

   // priority lookup for the two mapped class codes
   wire logic is_three = frame_is_ip && (frame_class == sgf_pkg::CLASS_THREE);
   wire logic is_two = frame_is_ip && (frame_class == sgf_pkg::CLASS_TWO);
   wire logic [1:0] next_prio = is_three ? prio_for_class_three :
                                is_two ? prio_for_class_two : 2'b00;

   // registered engine outputs
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         mcast_dest <= '0;
         mcast_forward <= 1'b0;
         frame_prio <= 2'b00;
         frame_prio_valid <= 1'b0;
         tag_insert <= '0;
         queue_egress_limit <= 1'b0;
         ingress_period <= sgf_pkg::RST_PERIOD;
         ingress_tick <= 1'b0;
      end else begin
         mcast_dest <= mcast_lookup ? next_dest : '0;
         mcast_forward <= next_forward;
         frame_prio <= next_prio;
         frame_prio_valid <= is_three || is_two;
         tag_insert <= next_tag;
         queue_egress_limit <= queue_mode;
         ingress_period <= period;
         ingress_tick <= timer_tick;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // ingress measuring window timer
   sgf_period_timer #(
      .CNT_W(CNT_W),
      .CYC_16(CYC_16),
      .CYC_64(CYC_64),
      .CYC_256(CYC_256)
   ) u_timer (
      .mclk(mclk),
      .rst(rst),
      .period_code(period),
      .tick(timer_tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // checks
   a_map_drop: assert property (@(posedge mclk) disable iff (rst)
      (mcast_lookup && mc_map == 5'h00) |=> !mcast_forward)
      else $error("zero port map still forwarded");
   a_map_ports: assert property (@(posedge mclk) disable iff (rst)
      (mcast_lookup && mc_fwd_en) |=> mcast_dest == PORTS'($past(mc_map)))
      else $error("destination differs from port map");
   a_fwd_gate: assert property (@(posedge mclk) disable iff (rst)
      !mc_fwd_en |=> (mcast_dest == '0) && !mcast_forward)
      else $error("forwarding while disabled");
   a_period_dec: assert property (@(posedge mclk) disable iff (rst)
      (wr_rt && reg_wdata[5]) |=> (period[1] && ingress_period == $past(period)))
      else $error("long period code not taken");
   a_queue_mode: assert property (@(posedge mclk) disable iff (rst)
      wr_rt |-> ##2 queue_egress_limit == $past(reg_wdata[3], 2))
      else $error("egress scheme not following bit 3");
   a_src_tag: assert property (@(posedge mclk) disable iff (rst)
      src_tag_sel |=> tag_insert == $past(src_port_tag_ctrl))
      else $error("per source tag select ignored");
   a_port_tag: assert property (@(posedge mclk) disable iff (rst)
      !src_tag_sel |=> tag_insert == $past(port_tag_ctrl))
      else $error("single tag bit not used");
   a_rev_read: assert property (@(posedge mclk) disable iff (rst)
      (reg_rd && hit_id) |=> reg_rdata == {REV_ID, 4'h0})
      else $error("revision read wrong");
   a_prio_three: assert property (@(posedge mclk) disable iff (rst)
      is_three |=> frame_prio_valid && frame_prio == $past(prio_for_class_three))
      else $error("class three priority wrong");
   a_prio_two: assert property (@(posedge mclk) disable iff (rst)
      is_two |=> frame_prio_valid && frame_prio == $past(prio_for_class_two))
      else $error("class two priority wrong");
   a_resv_zero: assert property (@(posedge mclk) disable iff (rst)
      (reg_rd && hit_rt) |=> (reg_rdata[7:6] == 2'b00) && (reg_rdata[1:0] == 2'b00))
      else $error("reserved bits not zero");

   ////////////////////////////////////////////////////////////////////////////
   // register storage checks

   // a write to the multicast control register lands on the next cycle
   a_mc_write: assert property (@(posedge mclk) disable iff (rst)
      wr_mc |=> (mc_map == $past(reg_wdata[4:0])) && (mc_fwd_en == $past(reg_wdata[5])))
      else $error("multicast control write lost");

   // a write to the rate and tag register lands on the next cycle
   a_rt_write: assert property (@(posedge mclk) disable iff (rst)
      wr_rt |=> (period == $past(reg_wdata[5:4])) && (src_tag_sel == $past(reg_wdata[2])))
      else $error("rate tag write lost");

   // the class map takes both mapped fields on a write
   a_cm_write: assert property (@(posedge mclk) disable iff (rst)
      wr_cm |=> (prio_for_class_three == $past(reg_wdata[7:6])) &&
                (prio_for_class_two == $past(reg_wdata[5:4])))
      else $error("class map write lost");

   // the egress scheme changes only through its own register
   a_queue_keep: assert property (@(posedge mclk) disable iff (rst)
      !wr_rt |=> $stable(queue_mode))
      else $error("egress scheme changed without a write");

   // the tag source selection changes only through its own register
   a_tag_keep: assert property (@(posedge mclk) disable iff (rst)
      !wr_rt |=> $stable(src_tag_sel))
      else $error("tag source changed without a write");

   ////////////////////////////////////////////////////////////////////////////
   // read port checks

   // read data stand only in the cycle after the strobe
   a_rd_idle: assert property (@(posedge mclk) disable iff (rst)
      !reg_rd |=> reg_rdata == 8'h00)
      else $error("read data without a read strobe");

   // the class map reads back what it holds
   a_rd_cm: assert property (@(posedge mclk) disable iff (rst)
      (reg_rd && hit_cm) |=> reg_rdata == $past(view_cm))
      else $error("class map read wrong");

   // unmapped addresses read as zero
   a_rd_unmap: assert property (@(posedge mclk) disable iff (rst)
      (reg_rd && !(hit_mc || hit_rt || hit_id || hit_cm)) |=> reg_rdata == 8'h00)
      else $error("unmapped address read not zero");

   // the top bit of the multicast control register is reserved
   a_resv_mc: assert property (@(posedge mclk) disable iff (rst)
      (reg_rd && hit_mc) |=> reg_rdata[7] == 1'b0)
      else $error("multicast reserved bit not zero");

   // the low nibble of the ident register is reserved
   a_resv_id: assert property (@(posedge mclk) disable iff (rst)
      (reg_rd && hit_id) |=> reg_rdata[3:0] == 4'h0)
      else $error("ident reserved bits not zero");

   ////////////////////////////////////////////////////////////////////////////
   // engine output checks

   // an all ones map floods when enabled
   a_flood_all: assert property (@(posedge mclk) disable iff (rst)
      (mcast_lookup && mc_fwd_en && mc_map == 5'h1F) |=> mcast_forward)
      else $error("all ones map did not flood");

   // without a lookup the destination stays empty
   a_lookup_idle: assert property (@(posedge mclk) disable iff (rst)
      !mcast_lookup |=> (mcast_dest == '0) && !mcast_forward)
      else $error("destination without a lookup");

   // the period output follows the register one cycle late
   a_period_copy: assert property (@(posedge mclk) disable iff (rst)
      1'b1 |=> ingress_period == $past(period))
      else $error("period output lags wrongly");

   // the window tick is a single cycle pulse
   a_tick_pulse: assert property (@(posedge mclk) disable iff (rst)
      ingress_tick |=> !ingress_tick)
      else $error("window tick longer than one cycle");

   // other classes and non IP frames carry no mapped priority
   a_prio_other: assert property (@(posedge mclk) disable iff (rst)
      (!is_three && !is_two) |=> !frame_prio_valid && (frame_prio == 2'b00))
      else $error("priority given to an unmapped class");
endmodule

// ===== sim/sgf_global_cfg_bench.sv
`timescale 1ns/1ns
module sgf_global_cfg_bench;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic mcast_lookup = 1'b0;
   logic [5:0] frame_class = 6'h00;
   logic frame_is_ip = 1'b0;
   logic [4:0] src_port_tag_ctrl = 5'h15;
   logic [4:0] port_tag_ctrl = 5'h0A;
   logic [4:0] mcast_dest;
   logic mcast_forward;
   logic [1:0] frame_prio;
   logic frame_prio_valid;
   logic [4:0] tag_insert;
   logic queue_egress_limit;
   logic [1:0] ingress_period;
   logic ingress_tick;
   int n_fail = 0;
   int cmp_count = 0;
   ////////////////////////////////////////////////////////////////////////////////
   // short windows keep the period checks quick
   sgf_global_cfg #(.PORTS(5), .CNT_W(27), .CYC_16(27'd8), .CYC_64(27'd16), .CYC_256(27'd32))
   u_sgf_global_cfg (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mcast_lookup(mcast_lookup),
      .frame_class(frame_class), .frame_is_ip(frame_is_ip),
      .src_port_tag_ctrl(src_port_tag_ctrl), .port_tag_ctrl(port_tag_ctrl),
      .mcast_dest(mcast_dest), .mcast_forward(mcast_forward), .frame_prio(frame_prio),
      .frame_prio_valid(frame_prio_valid), .tag_insert(tag_insert),
      .queue_egress_limit(queue_egress_limit), .ingress_period(ingress_period),
      .ingress_tick(ingress_tick));
   // 4 ns clock
   always #2 mclk = ~mclk;
   ////////////////////////////////////////////////////////////////////////////////
   // shared compare and bus cycles
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         $display("mismatch %s expected %h seen %h", nm, e, g);
         n_fail++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 chk(nm, e, reg_rdata);
   endtask
   // one engine request, outputs looked at one cycle later
   task automatic eng(input logic lk, input logic [5:0] cls, input logic ip);
      @(posedge mclk);
      mcast_lookup <= lk;
      frame_class <= cls;
      frame_is_ip <= ip;
      @(posedge mclk);
      #1;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_reset();
      chk("period out", 8'h01, {6'h00, ingress_period});
      rd(8'h86, 8'h00, "mcast ctrl");
      rd(8'h87, 8'h10, "rate tag");
      rd(8'h89, 8'hA0, "ident");
      rd(8'h90, 8'h00, "class map");
      $display("test reset done");
   endtask
   task automatic t_mcast();
      logic [7:0] w [6] = '{8'h01, 8'h21, 8'h22, 8'h23, 8'h3F, 8'h20};
      logic [4:0] e [6] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h1F, 5'h00};
      for (int i = 0; i < 6; i++) begin
         wr(8'h86, w[i]);
         eng(1'b1, 6'h00, 1'b1);
         chk("mcast dest", {3'b000, e[i]}, {3'b000, mcast_dest});
         chk("mcast fwd", {7'h00, e[i] != 5'h00}, {7'h00, mcast_forward});
      end
      eng(1'b0, 6'h00, 1'b0);
      $display("test mcast done");
   endtask
   task automatic t_period();
      int cyc [4] = '{8, 16, 32, 32};
      int n;
      for (int c = 0; c < 4; c++) begin
         wr(8'h87, {2'b00, 2'(c), 4'h0});
         n = 0;
         do begin @(posedge mclk); #1; n++; end while (ingress_tick !== 1'b1 && n < 100);
         n = 0;
         do begin @(posedge mclk); #1; n++; end while (ingress_tick !== 1'b1 && n < 100);
         chk("tick gap", 8'(cyc[c]), 8'(n));
         chk("period out", 8'(c), {6'h00, ingress_period});
      end
      $display("test period done");
   endtask
   task automatic t_tag_queue();
      wr(8'h87, 8'h10);
      eng(1'b0, 6'h00, 1'b0);
      chk("tag plain", 8'h0A, {3'b000, tag_insert});
      chk("queue off", 8'h00, {7'h00, queue_egress_limit});
      wr(8'h87, 8'hFF);
      eng(1'b0, 6'h00, 1'b0);
      chk("tag src", 8'h15, {3'b000, tag_insert});
      chk("queue on", 8'h01, {7'h00, queue_egress_limit});
      rd(8'h87, 8'h3C, "rate tag rsvd");
      wr(8'h86, 8'hFF);
      rd(8'h86, 8'h7F, "mcast rsvd");
      wr(8'h89, 8'h55);
      rd(8'h89, 8'hA0, "ident ro");
      wr(8'h88, 8'hFF);
      rd(8'h88, 8'h00, "unmapped");
      $display("test tag queue done");
   endtask
   task automatic t_class();
      wr(8'h90, 8'hB4);
      rd(8'h90, 8'hB4, "class map rw");
      eng(1'b0, 6'h03, 1'b1);
      chk("prio three", 8'h06, {5'h00, frame_prio_valid, frame_prio});
      eng(1'b0, 6'h02, 1'b1);
      chk("prio two", 8'h07, {5'h00, frame_prio_valid, frame_prio});
      eng(1'b0, 6'h01, 1'b1);
      chk("prio other", 8'h00, {5'h00, frame_prio_valid, frame_prio});
      eng(1'b0, 6'h03, 1'b0);
      chk("prio non ip", 8'h00, {5'h00, frame_prio_valid, frame_prio});
      $display("test class done");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // verdict and stop
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      #1;
      t_reset();
      t_mcast();
      t_period();
      t_tag_queue();
      t_class();
      report_and_stop();
   end
   // watchdog, tests need well under 2000 cycles
   initial begin
      #40000;
      n_fail++;
      report_and_stop();
   end
endmodule
